/* File: pkg/gpio_pkg.sv */
/*
 * Constants, types and register map of the two-port pin multiplexing GPIO block.
 * Assumes a word-addressed Avalon-MM slave port: the bus address is the register index.
 */
// Functional notes
// - Interrupt-capable pin is general input when select is 0, interrupt input when 1.
// - Transmit pin drives serial data when pin enable and transmitter enable both set.
// - Receive pin feeds serial receiver when receiver enable is 1, else general I/O.
// - Clock pin: all selects 0 general I/O, internal clock output, external clock input.
// - Four-pin port high impedance in reset, standby and watch, held in sleep and subsleep, live otherwise.
// - Reading eight-pin data returns latch value for bits with direction 1.
// - Reading eight-pin data returns pin level for bits with direction 0.
// - Eight-pin direction bit 1 makes the pin output, 0 makes it input.
// - Direction and data apply only while pin is general I/O by mode and segment bits.
// - Eight-pin direction register is writable but always reads all ones.
// - Eight-pin data and direction registers reset to zero, all pins inputs.
// - Non-segment eight-pin pin is general I/O at mode 0, wakeup input at mode 1.
// - Pull-up on only when direction is 0 and pull-up bit is 1; off after reset.
package gpio_pkg;

    // ==========================================================
    // Register indices (word address on the bus)
    localparam logic [15:0] port5_pin_mode_idx = 16'hFFCC;
    localparam logic [15:0] port4_data_latch_idx = 16'hFFD7;
    localparam logic [15:0] port5_data_latch_idx = 16'hFFD8;
    localparam logic [15:0] port5_pullup_control_idx = 16'hFFE2;
    localparam logic [15:0] port4_direction_idx = 16'hFFE7;
    localparam logic [15:0] port5_direction_idx = 16'hFFE8;
    localparam logic [15:0] port4_function_control_idx = 16'hFFF0;
    localparam logic [15:0] lcd_port_control_idx = 16'hFFF1;

    // ==========================================================
    // Reset values and fixed read-back values
    localparam logic [7:0] port5_reset_value = 8'h00;
    localparam logic [2:0] port4_reset_value = 3'h0;
    localparam logic [7:0] write_only_read_value = 8'hFF;
    localparam logic [3:0] port4_unused_read_value = 4'hF;

    // ==========================================================
    // Field positions of port4_function_control
    localparam int external_interrupt_select_pos = 0;
    localparam int serial_pin_enable_pos = 1;
    localparam int transmitter_enable_pos = 2;
    localparam int receiver_enable_pos = 3;
    localparam int clock_enable_low_pos = 4;
    localparam int clock_enable_high_pos = 5;
    localparam int communication_mode_select_pos = 6;
    // Field of lcd_port_control: segment_select_bits[3:0]; top bit hands port 5 to the LCD
    localparam int segment_select_top_pos = 3;

    // ==========================================================
    // Power modes, one-hot
    typedef enum logic [5:0] {
        mode_active = 6'h01,
        mode_subactive = 6'h02,
        mode_sleep = 6'h04,
        mode_subsleep = 6'h08,
        mode_watch = 6'h10,
        mode_standby = 6'h20
    } power_mode_t;

    // Pin-function selects of the four-pin port
    typedef struct packed {
        logic communication_mode_select;
        logic clock_enable_high;
        logic clock_enable_low;
        logic receiver_enable;
        logic transmitter_enable;
        logic serial_pin_enable;
        logic external_interrupt_select;
    } port4_function_t;

    // Pad drive of one port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pad_drive_t;

endpackage

/* File: src/dual_port_pin_mux_gpio.sv */
/*
 * Pin multiplexing and general I/O for the four-pin and eight-pin ports, with an
 * Avalon-MM register slave. Assumes pad inputs are asynchronous, that the serial channel,
 * LCD driver and power controller run on clk, and that pads resolve out/oe themselves.
 * Also assumes the bus address is a register index and that only the low byte lane
 * carries data; upper write lanes are ignored and upper read lanes return zero.
 */
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/100ps
module dual_port_pin_mux_gpio
    import gpio_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Avalon-MM slave
    input wire logic [15:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Four-pin port pads
    input wire logic [3:0] port4_pin_in,
    output logic [3:0] port4_pin_out,
    output logic [3:0] port4_pin_oe,
    // Eight-pin port pads
    input wire logic [7:0] port5_pin_in,
    output logic [7:0] port5_pin_out,
    output logic [7:0] port5_pin_oe,
    output logic [7:0] port5_pullup_en,
    // Serial channel side
    input wire logic serial_tx_data,
    input wire logic serial_clk_out,
    output logic serial_rx_data,
    output logic serial_clk_in,
    // Interrupt, wakeup and LCD side
    output logic irq_request,
    output logic [7:0] wakeup_request,
    output logic [7:0] segment_mode,
    // Power mode from the system controller
    input wire power_mode_t power_mode
);

    // ==========================================================
    // Pad synchronisers
    logic [3:0] p4_meta_q;
    logic [3:0] p4_sync_q;
    logic [7:0] p5_meta_q;
    logic [7:0] p5_sync_q;

    // Two stages; only the second stage is read by logic
    // Stages reset low; no edge detector reads them, so no false edge follows reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            p4_meta_q <= 4'h0;
            p4_sync_q <= 4'h0;
            p5_meta_q <= 8'h00;
            p5_sync_q <= 8'h00;
        end else begin
            p4_meta_q <= port4_pin_in;
            p4_sync_q <= p4_meta_q;
            p5_meta_q <= port5_pin_in;
            p5_sync_q <= p5_meta_q;
        end
    end

    // ==========================================================
    // Registers
    logic [7:0] port5_data_latch_q;
    logic [7:0] port5_direction_q;
    logic [7:0] port5_pullup_control_q;
    logic [7:0] port5_pin_mode_q;
    // Port 4 keeps only the three writable bits; pin 3 has no latch or direction
    logic [2:0] port4_data_latch_q;
    logic [2:0] port4_direction_q;
    port4_function_t port4_function_q;
    logic [3:0] lcd_port_control_q;

    // Bus handshake: one wait cycle, write commits when waitrequest is seen low
    logic waitrequest_q;
    logic [31:0] readdata_q;
    logic commit;

    // A write lands only in the answer cycle, so a strobe held into it cannot write twice
    assign commit = write && !waitrequest_q;

    // Read-back mixing latch and pin per direction bit
    function automatic logic [7:0] port_read(input logic [7:0] latch, input logic [7:0] dir,
                                             input logic [7:0] pins);
        port_read = (latch & dir) | (pins & ~dir);
    endfunction

    // Byte read value for a register index; unmapped reads as zero
    function automatic logic [7:0] read_mux(input logic [15:0] idx);
        logic [7:0] p4_mix;
        // Pins 2..0 mix latch and pin per direction; pin 3 is input only
        p4_mix = port_read({5'h00, port4_data_latch_q}, {5'h00, port4_direction_q},
                           {5'h00, p4_sync_q[2:0]});
        case (idx)
            port5_data_latch_idx: read_mux = port_read(port5_data_latch_q, port5_direction_q, p5_sync_q);
            port5_direction_idx: read_mux = write_only_read_value;
            port5_pullup_control_idx: read_mux = port5_pullup_control_q;
            port5_pin_mode_idx: read_mux = port5_pin_mode_q;
            port4_data_latch_idx: read_mux = {port4_unused_read_value, p4_sync_q[3], p4_mix[2:0]};
            port4_direction_idx: read_mux = write_only_read_value;
            port4_function_control_idx: read_mux = {1'b0, port4_function_q};
            lcd_port_control_idx: read_mux = {4'h0, lcd_port_control_q};
            default: read_mux = 8'h00;
        endcase
    endfunction

    // Waitrequest and read data
    // Unmapped indices are answered too, so a stray access never stalls the master
    // Read data is captured at the edge that first sees the request and drops waitrequest, and stands until the next access
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            waitrequest_q <= 1'b1;
            readdata_q <= 32'h0000_0000;
        end else if ((read || write) && waitrequest_q) begin
            waitrequest_q <= 1'b0;
            readdata_q <= {24'h00_0000, read_mux(address)};
        end else begin
            waitrequest_q <= 1'b1;
        end
    end

    // Eight-pin port registers; writes to unmapped indices are dropped
    // The direction byte is write-only; read_mux returns ones for it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            port5_data_latch_q <= port5_reset_value;
            port5_direction_q <= port5_reset_value;
            port5_pullup_control_q <= port5_reset_value;
            port5_pin_mode_q <= port5_reset_value;
        end else if (commit) begin
            case (address)
                port5_data_latch_idx: port5_data_latch_q <= writedata[7:0];
                port5_direction_idx: port5_direction_q <= writedata[7:0];
                port5_pullup_control_idx: port5_pullup_control_q <= writedata[7:0];
                port5_pin_mode_idx: port5_pin_mode_q <= writedata[7:0];
                default: port5_data_latch_q <= port5_data_latch_q;
            endcase
        end
    end

    // Four-pin port and pin-function registers
    // Bit 7 of the function control byte has no field and is dropped on write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            port4_data_latch_q <= port4_reset_value;
            port4_direction_q <= port4_reset_value;
            port4_function_q <= '0;
            lcd_port_control_q <= 4'h0;
        end else if (commit) begin
            case (address)
                port4_data_latch_idx: port4_data_latch_q <= writedata[2:0];
                port4_direction_idx: port4_direction_q <= writedata[2:0];
                port4_function_control_idx: port4_function_q <= port4_function_t'(writedata[6:0]);
                lcd_port_control_idx: lcd_port_control_q <= writedata[3:0];
                default: port4_data_latch_q <= port4_data_latch_q;
            endcase
        end
    end

    // ==========================================================
    // Four-pin port function decode
    logic tx_active;
    logic rx_active;
    logic sck_out_sel;
    logic sck_in_sel;
    logic [3:0] p4_out_d;
    logic [3:0] p4_oe_d;

    assign tx_active = port4_function_q.serial_pin_enable && port4_function_q.transmitter_enable;
    assign rx_active = port4_function_q.receiver_enable;
    // External clock wins over both internal selections
    assign sck_in_sel = port4_function_q.clock_enable_high;
    assign sck_out_sel = !port4_function_q.clock_enable_high &&
                         (port4_function_q.clock_enable_low || port4_function_q.communication_mode_select);

    // Pad drive per pin function
    // Pins owned by a peripheral input keep the undriven defaults
    always_comb begin
        p4_out_d = 4'h0;
        p4_oe_d = 4'h0;
        // Pin 3 is input only, as general input or interrupt request
        if (tx_active) begin
            p4_out_d[2] = serial_tx_data;
            p4_oe_d[2] = 1'b1;
        end else begin
            p4_out_d[2] = port4_data_latch_q[2];
            p4_oe_d[2] = port4_direction_q[2];
        end
        if (!rx_active) begin
            p4_out_d[1] = port4_data_latch_q[1];
            p4_oe_d[1] = port4_direction_q[1];
        end
        if (sck_out_sel) begin
            p4_out_d[0] = serial_clk_out;
            p4_oe_d[0] = 1'b1;
        end else if (!sck_in_sel) begin
            p4_out_d[0] = port4_data_latch_q[0];
            p4_oe_d[0] = port4_direction_q[0];
        end
    end

    // ==========================================================
    // Eight-pin port function decode
    logic lcd_owns_port5;
    logic [7:0] p5_gpio_sel;
    logic [7:0] p5_out_d;
    logic [7:0] p5_oe_d;
    logic [7:0] p5_pullup_d;

    // Only the top segment-select bit matters here; the low bits set LCD duty elsewhere
    assign lcd_owns_port5 = lcd_port_control_q[segment_select_top_pos];
    // General I/O only with mode bit clear and no segment use
    assign p5_gpio_sel = lcd_owns_port5 ? 8'h00 : ~port5_pin_mode_q;
    assign p5_out_d = port5_data_latch_q & p5_gpio_sel;
    assign p5_oe_d = port5_direction_q & p5_gpio_sel;
    // Pull-up follows direction and control bit only, independent of mode
    assign p5_pullup_d = ~port5_direction_q & port5_pullup_control_q;

    // ==========================================================
    // Power-mode gating of pad drive
    logic pads_off;
    logic pads_hold;

    // Standby and watch float pads; sleep and subsleep freeze them
    assign pads_off = (power_mode == mode_standby) || (power_mode == mode_watch);
    assign pads_hold = (power_mode == mode_sleep) || (power_mode == mode_subsleep);
    // Power mode comes from the controller on clk, so it needs no synchroniser

    // Live or held drive per power mode; one policy serves both ports
    function automatic pad_drive_t pad_gate(input pad_drive_t live, input pad_drive_t held);
        if (pads_off) begin
            pad_gate = '0;
        end else if (pads_hold) begin
            pad_gate = held;
        end else begin
            pad_gate = live;
        end
    endfunction

    // Port 4 rides in the low nibble of each carrier field; the top nibble stays zero
    pad_drive_t p4_drive_d;
    pad_drive_t p5_drive_d;

    assign p4_drive_d = pad_gate({4'h0, p4_out_d, 4'h0, p4_oe_d}, {4'h0, port4_pin_out, 4'h0, port4_pin_oe});
    assign p5_drive_d = pad_gate({p5_out_d, p5_oe_d}, {port5_pin_out, port5_pin_oe});

    // Pad outputs; reset floats every pad
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            port4_pin_out <= 4'h0;
            port4_pin_oe <= 4'h0;
            port5_pin_out <= 8'h00;
            port5_pin_oe <= 8'h00;
        end else begin
            port4_pin_out <= p4_drive_d.out[3:0];
            port4_pin_oe <= p4_drive_d.oe[3:0];
            port5_pin_out <= p5_drive_d.out;
            port5_pin_oe <= p5_drive_d.oe;
        end
    end

    // Pull-up enables; kept alive in standby so floating pins read high
    // A pull-up on a driven pin would fight the output, so direction gates it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            port5_pullup_en <= 8'h00;
        end else begin
            port5_pullup_en <= p5_pullup_d;
        end
    end

    // ==========================================================
    // Inputs handed to peripherals, gated by pin function
    // Peripherals see a pin change three edges late: two sync stages and this one
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_request <= 1'b0;
            serial_rx_data <= 1'b1;
            serial_clk_in <= 1'b0;
            wakeup_request <= 8'h00;
            segment_mode <= 8'h00;
        end else begin
            irq_request <= port4_function_q.external_interrupt_select && p4_sync_q[3];
            // Idle line level while the receiver does not own the pin
            serial_rx_data <= rx_active ? p4_sync_q[1] : 1'b1;
            serial_clk_in <= sck_in_sel && p4_sync_q[0];
            wakeup_request <= lcd_owns_port5 ? 8'h00 : (port5_pin_mode_q & ~p5_sync_q);
            segment_mode <= {8{lcd_owns_port5}};
        end
    end

    // ==========================================================
    // Bus outputs
    // Both come straight from flops, which the one-wait-cycle timing relies on
    assign readdata = readdata_q;
    assign waitrequest = waitrequest_q;

endmodule

/* File: tb/pad_model.sv */
/*
 * Behavioural pads of one port, standing for the board side.
 * Assumes the bench always drives a defined outside level on every pin.
 */
`timescale 1ns/100ps
module pad_model #(
    parameter int W = 8
) (
    // Drive from the design
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] oe,
    // Level driven from outside
    input wire logic [W-1:0] ext,
    // Level seen by the design
    output logic [W-1:0] level
);
    // A driven pad shows its own output, an undriven one the outside level
    always_comb level = (oe & out) | (~oe & ext);
endmodule

/* File: tb/gpio_asserts.sv */
/*
 * Checker of the pin mux GPIO block, bound to its top module.
 * Assumes it sees only the ports of that module, on one clock.
 */
`timescale 1ns/100ps
module gpio_asserts
    import gpio_pkg::*;
(
    // Clock, reset and bus
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Pads and serial side
    input wire logic [3:0] port4_pin_out,
    input wire logic [3:0] port4_pin_oe,
    input wire logic [7:0] port5_pin_oe,
    input wire logic [7:0] port5_pullup_en,
    input wire logic serial_clk_in,
    input wire power_mode_t power_mode
);
    // ==========================================================
    // Shared clocking and sequences
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_req;
        (read || write) && waitrequest;
    endsequence
    sequence s_answer;
        !waitrequest ##1 waitrequest;
    endsequence
    // ==========================================================
    // Bus timing and register reads
    property p_answer; s_req |=> s_answer; endproperty
    a_answer: assert property (p_answer) else $error("bus answer late");
    property p_no_spurious; !waitrequest |-> $past(read || write); endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("answer without request");
    property p_dir_ones; s_req ##0 (read && address == 16'hFFE8) |=> readdata[7:0] == 8'hFF; endproperty
    a_dir_ones: assert property (p_dir_ones) else $error("direction read not ones");
    // ==========================================================
    // Pad rules
    property p_reset_inputs; $rose(resetn) |-> port5_pin_oe == 8'h00; endproperty
    a_reset_inputs: assert property (p_reset_inputs) else $error("pin driven after reset");
    property p_pullup; (port5_pullup_en & port5_pin_oe) == 8'h00; endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up on driven pin");
    property p_standby; (power_mode == mode_standby) [*2] |-> port4_pin_oe == 4'h0; endproperty
    a_standby: assert property (p_standby) else $error("driven in standby");
    property p_sleep;
        (power_mode == mode_sleep) [*2] |=> $stable(port4_pin_oe) && $stable(port4_pin_out);
    endproperty
    a_sleep: assert property (p_sleep) else $error("pins moved in sleep");
    property p_irq_pin; port4_pin_oe[3] == 1'b0; endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin driven");
    property p_clk_in; serial_clk_in |-> !port4_pin_oe[0]; endproperty
    a_clk_in: assert property (p_clk_in) else $error("clock input pin driven");
endmodule
bind dual_port_pin_mux_gpio gpio_asserts chk (.clk(clk), .resetn(resetn), .address(address), .read(read),
    .write(write), .readdata(readdata), .waitrequest(waitrequest), .port4_pin_out(port4_pin_out),
    .port4_pin_oe(port4_pin_oe), .port5_pin_oe(port5_pin_oe), .port5_pullup_en(port5_pullup_en),
    .serial_clk_in(serial_clk_in), .power_mode(power_mode));

/* File: tb/dual_port_pin_mux_gpio_bench.sv */
/*
 * Self-checking bench of the pin mux GPIO block.
 * Assumes the package, pad model and checker are compiled first.
 */
`timescale 1ns/100ps
module dual_port_pin_mux_gpio_bench;
    import gpio_pkg::*;
    logic clk, resetn, read, write, waitrequest, tx, sck_out, rx, sck_in, irq;
    logic [15:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [3:0] p4_out, p4_oe, p4_in, ext4;
    logic [7:0] p5_out, p5_oe, p5_in, ext5, pull, wake, seg;
    power_mode_t mode;
    int fail_count, checked;
    dual_port_pin_mux_gpio dut (.clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .port4_pin_in(p4_in),
        .port4_pin_out(p4_out), .port4_pin_oe(p4_oe), .port5_pin_in(p5_in), .port5_pin_out(p5_out),
        .port5_pin_oe(p5_oe), .port5_pullup_en(pull), .serial_tx_data(tx), .serial_clk_out(sck_out),
        .serial_rx_data(rx), .serial_clk_in(sck_in), .irq_request(irq), .wakeup_request(wake),
        .segment_mode(seg), .power_mode(mode));
    pad_model #(.W(4)) pads4 (.out(p4_out), .oe(p4_oe), .ext(ext4), .level(p4_in));
    pad_model #(.W(8)) pads5 (.out(p5_out), .oe(p5_oe), .ext(ext5), .level(p5_in));
    // ==========================================================
    // Clock, verdict and shared tasks
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, s);
            fail_count++;
        end
    endtask
    // Holds the request until waitrequest is seen low; rd takes read data there
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        address <= a;
        writedata <= {24'h000000, d};
        write <= w;
        read <= !w;
        do @(posedge clk); while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    // Covers the two-stage pad sync and the registered pad drive
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk("oe after reset", 8'h00, p5_oe);
        bus(0, 16'hFFCC, 8'h00);
        chk("pin mode", 8'h00, rd);
        bus(0, 16'hFFE2, 8'h00);
        chk("pullup ctl", 8'h00, rd);
        bus(1, 16'h0010, 8'h5A);
        bus(0, 16'h0010, 8'h00);
        chk("unmapped", 32'h00000000, rd);
    endtask
    task automatic t_port5();
        bus(1, 16'hFFE8, 8'hFF);
        settle();
        chk("latch reset", 8'h00, p5_out);
        bus(1, 16'hFFE8, 8'h0F);
        bus(1, 16'hFFD8, 8'hA5);
        ext5 <= 8'h3C;
        bus(1, 16'hFFE2, 8'hFF);
        settle();
        chk("p5 oe", 8'h0F, p5_oe);
        chk("p5 out", 8'h05, p5_out & 8'h0F);
        chk("pullup", 8'hF0, pull);
        bus(0, 16'hFFD8, 8'h00);
        chk("p5 read", 8'h35, rd);
        bus(0, 16'hFFE8, 8'h00);
        chk("dir read", 8'hFF, rd);
    endtask
    task automatic t_mode();
        bus(1, 16'hFFCC, 8'h30);
        ext5 <= 8'h00;
        settle();
        chk("wakeup", 8'h30, wake);
        bus(1, 16'hFFF1, 8'h08);
        settle();
        chk("segment", 8'hFF, seg);
        chk("wake in lcd", 8'h00, wake);
        chk("oe in lcd", 8'h00, p5_oe);
        bus(0, 16'hFFD8, 8'h00);
        chk("latch read in lcd", 8'h05, rd);
        bus(1, 16'hFFF1, 8'h00);
        bus(1, 16'hFFCC, 8'h00);
    endtask
    task automatic t_port4();
        logic [7:0] fs [2];
        fs = '{8'h10, 8'h40};
        bus(1, 16'hFFE7, 8'h07);
        bus(1, 16'hFFD7, 8'h05);
        ext4 <= 4'h8;
        tx <= 1'b1;
        settle();
        chk("p4 oe gpio", 4'h7, p4_oe);
        chk("p4 out gpio", 4'h5, p4_out & 4'h7);
        chk("irq off", 1'b0, irq);
        bus(1, 16'hFFF0, 8'h2F);
        ext4 <= 4'h9;
        settle();
        chk("irq on", 1'b1, irq);
        chk("p4 oe serial", 4'h4, p4_oe);
        chk("tx high", 1'b1, p4_out[2]);
        chk("rx", 1'b0, rx);
        chk("clk in", 1'b1, sck_in);
        @(posedge clk);
        tx <= 1'b0;
        ext4 <= 4'h8;
        settle();
        chk("tx low", 1'b0, p4_out[2]);
        // Each internal clock select drives the clock pin, not the latch
        foreach (fs[i]) begin
            bus(1, 16'hFFF0, fs[i]);
            settle();
            chk("p4 oe clk out", 4'h7, p4_oe);
            chk("p4 out clk out", 4'h4, p4_out & 4'h7);
            chk("rx idle", 1'b1, rx);
        end
        @(posedge clk);
        sck_out <= 1'b1;
        settle();
        chk("clk out high", 4'h5, p4_out & 4'h7);
        @(posedge clk);
        sck_out <= 1'b0;
    endtask
    task automatic t_power();
        @(posedge clk);
        mode <= mode_standby;
        settle();
        chk("standby oe", 4'h0, p4_oe);
        chk("standby p5 oe", 8'h00, p5_oe);
        @(posedge clk);
        mode <= mode_active;
        settle();
        @(posedge clk);
        mode <= mode_sleep;
        bus(1, 16'hFFD7, 8'h02);
        settle();
        chk("sleep oe", 4'h7, p4_oe);
        chk("sleep out", 4'h4, p4_out & 4'h7);
        @(posedge clk);
        mode <= mode_subactive;
        settle();
        chk("subactive out", 4'h2, p4_out & 4'h7);
        @(posedge clk);
        mode <= mode_subsleep;
        bus(1, 16'hFFD7, 8'h05);
        settle();
        chk("subsleep out", 4'h2, p4_out & 4'h7);
        @(posedge clk);
        mode <= mode_watch;
        settle();
        chk("watch oe", 4'h0, p4_oe);
        @(posedge clk);
        mode <= mode_active;
    endtask
    // Reset in mid-run: registers and pads go back to their reset state
    task automatic t_rereset();
        @(posedge clk);
        resetn <= 1'b0;
        ext5 <= 8'h5A;
        repeat (2) @(posedge clk);
        chk("reset p4 oe", 4'h0, p4_oe);
        chk("reset p5 oe", 8'h00, p5_oe);
        chk("reset pullup", 8'h00, pull);
        resetn <= 1'b1;
        settle();
        bus(0, 16'hFFD8, 8'h00);
        chk("reset p5 read", 8'h5A, rd);
        bus(0, 16'hFFD7, 8'h00);
        chk("reset p4 read", 8'hF8, rd);
        bus(0, 16'hFFE2, 8'h00);
        chk("reset pullup ctl", 8'h00, rd);
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        resetn = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 16'h0000;
        writedata = 32'h00000000;
        ext4 = 4'h0;
        ext5 = 8'h00;
        tx = 1'b0;
        sck_out = 1'b0;
        mode = mode_active;
        fail_count = 0;
        checked = 0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_port5();
        t_mode();
        t_port4();
        t_power();
        t_rereset();
        complete_run();
    end
    // Tests need a few hundred cycles; ten thousand means a hung handshake
    initial begin
        #400000;
        fail_count++;
        complete_run();
    end
endmodule
